// ### verilog/crst_top.sv
/*
  clock/reset status register, clock guard flag, time base counter, halt mode
  control and half-rate clock output, behind an axi4-lite slave.
  assumes reset cause, option and oscillator status levels synchronous to aclk,
  and that aresetn is held while a reset cause is presented.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// R1: unused bits of both registers always read as zero
// R2: brownout flag set by brownout reset, cleared only by software writing zero
// R3: brownout flag value is undefined while the brownout detector is disabled
// R4: clock guard irq enable is read/write, gates the guard request, void if guard off
// R5: safe clock flag set on backup oscillator use, read clears after recovery
// R6: safe clock flag held at zero while the clock guard is disabled
// R7: watchdog flag set by watchdog reset, cleared by writing zero or brownout reset
// R8: reset cause coding: pin 00, watchdog 01, brownout 1x
// R9: uncleared brownout flag survives later pin or watchdog resets
// R10: reset status register resets to zero except cause-driven flag bits
// R11: clock-out enable drives a pin with oscillator clock divided by two
// R12: clock-out stops toggling during timed halt
// R13: two-bit select gives periods of 32000, 64000, 160000, 400000 cycles
// R14: a new time base select takes effect only at the end of a period
// R15: time base irq enable is read/write; halt request then enters timed halt
// R16: elapsed flag set each period, cleared by reading the main control register
// R17: main control register resets to 01h
// R18: software must avoid read-modify-write on the main control register
// R19: time base and clock guard requests share one halt-waking interrupt
// R20: clock source returns to the main oscillator once it recovers
// R21: each request is asserted while its flag and its enable are both set
// R22: counter restarts at zero on reaching the period, setting the elapsed flag
module crst_top #(
  parameter int unsigned TB_PERIOD_0 = crst_pkg::TB_PERIOD_0,
  parameter int unsigned TB_PERIOD_1 = crst_pkg::TB_PERIOD_1,
  parameter int unsigned TB_PERIOD_2 = crst_pkg::TB_PERIOD_2,
  parameter int unsigned TB_PERIOD_3 = crst_pkg::TB_PERIOD_3
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        brownout_reset_cause,
  input  wire logic        watchdog_reset_cause,
  input  wire logic        brownout_detector_enable,
  input  wire logic        clock_guard_enable,
  input  wire logic        osc_failed,
  input  wire logic        clock_out_enable,
  input  wire logic        halt_request,
  input  wire logic        halt_wake,
  output logic             clock_use_safe,
  output logic             clock_out,
  output logic             clock_out_oe,
  output logic             halt_active,
  output logic             timed_halt_active,
  output logic             timebase_irq_req,
  output logic             clock_guard_irq_req,
  output logic             shared_irq
);

  function automatic crst_pkg::crst_sel_t crst_decode(input logic [7:0] addr);
    crst_pkg::crst_sel_t sel;
    sel = crst_pkg::CRST_SEL_NONE;
    if (addr == crst_pkg::MAIN_CLK_CTRL_ADDR) begin
      sel = crst_pkg::CRST_SEL_MAIN;
    end else if (addr == crst_pkg::RST_SRC_ADDR) begin
      sel = crst_pkg::CRST_SEL_RST;
    end
    return sel;
  endfunction

  logic                     awready_q;
  logic                     aw_have_q;
  logic [7:0]               awaddr_q;
  logic                     wready_q;
  logic                     w_have_q;
  logic [7:0]               wbyte_q;
  logic                     wstrb0_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     arready_q;
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic [1:0]               tb_sel_q;
  logic                     tb_ie_q;
  logic                     elapsed_q;
  logic                     guard_ie_q;
  logic                     safe_q;
  logic                     brownout_q;
  logic                     watchdog_q;
  logic [1:0]               sel_act_q;
  logic [crst_pkg::TB_CNT_W-1:0] cnt_q;
  logic [crst_pkg::TB_CNT_W-1:0] limit;
  logic                     tb_wrap;
  crst_pkg::crst_state_t    state_q;
  logic                     halt_q;
  logic                     thalt_q;
  logic                     use_safe_q;
  logic                     clk_out_q;
  logic                     clk_oe_q;
  logic                     tb_req_q;
  logic                     guard_req_q;
  logic                     irq_q;
  logic                     wr_fire;
  crst_pkg::crst_sel_t      wr_sel;
  crst_pkg::crst_sel_t      rd_sel;
  crst_pkg::crst_sel_t      rd_sel_q;
  logic                     rd_fire;
  logic                     wr_main;
  logic                     wr_rst;
  logic                     rd_main;
  logic                     rd_rst;
  logic [7:0]               main_val;
  logic [7:0]               rst_val;

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign clock_use_safe      = use_safe_q;
  assign clock_out           = clk_out_q;
  assign clock_out_oe        = clk_oe_q;
  assign halt_active         = halt_q;
  assign timed_halt_active   = thalt_q;
  assign timebase_irq_req    = tb_req_q;
  assign clock_guard_irq_req = guard_req_q;
  assign shared_irq          = irq_q;

  // bus decode; only byte lane 0 carries register data
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_sel  = crst_decode(awaddr_q);
  assign wr_main = wr_fire && wstrb0_q && (wr_sel == crst_pkg::CRST_SEL_MAIN);
  assign wr_rst  = wr_fire && wstrb0_q && (wr_sel == crst_pkg::CRST_SEL_RST);
  assign rd_fire = s_axi_arvalid && arready_q;
  assign rd_sel  = crst_decode(s_axi_araddr);
  assign rd_main = rd_fire && (rd_sel == crst_pkg::CRST_SEL_MAIN);
  assign rd_rst  = rd_fire && (rd_sel == crst_pkg::CRST_SEL_RST);

  // reserved bits tie to zero
  always_comb begin
    main_val = 8'h00; // see R1
    main_val[crst_pkg::TB_SEL_HI_BIT:crst_pkg::TB_SEL_LO_BIT] = tb_sel_q;
    main_val[crst_pkg::TB_IE_BIT]   = tb_ie_q;
    main_val[crst_pkg::ELAPSED_BIT] = elapsed_q;
    rst_val = 8'h00; // see R1
    rst_val[crst_pkg::BOR_RF_BIT]   = brownout_q;
    rst_val[crst_pkg::GUARD_IE_BIT] = guard_ie_q;
    rst_val[crst_pkg::SAFE_CLK_BIT] = safe_q;
    rst_val[crst_pkg::WDG_RF_BIT]   = watchdog_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wbyte_q  <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= crst_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == crst_pkg::CRST_SEL_NONE) ? crst_pkg::RESP_SLVERR : crst_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read data is the value before any read-to-clear side effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= crst_pkg::RESP_OKAY;
      rd_sel_q  <= crst_pkg::CRST_SEL_NONE;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rd_sel_q  <= rd_sel;
      case (rd_sel)
        crst_pkg::CRST_SEL_MAIN: begin
          rdata_q <= {24'h000000, main_val};
          rresp_q <= crst_pkg::RESP_OKAY;
        end
        crst_pkg::CRST_SEL_RST: begin
          rdata_q <= {24'h000000, rst_val};
          rresp_q <= crst_pkg::RESP_OKAY;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= crst_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // main control register: select and enable are plain read/write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_sel_q <= crst_pkg::MAIN_CLK_CTRL_RESET[crst_pkg::TB_SEL_HI_BIT:crst_pkg::TB_SEL_LO_BIT]; // see R17
      tb_ie_q  <= crst_pkg::MAIN_CLK_CTRL_RESET[crst_pkg::TB_IE_BIT];
    end else if (wr_main) begin
      tb_sel_q <= wbyte_q[crst_pkg::TB_SEL_HI_BIT:crst_pkg::TB_SEL_LO_BIT]; // see R13
      tb_ie_q  <= wbyte_q[crst_pkg::TB_IE_BIT]; // see R15
    end
  end

  // period end beats a same-cycle read so no elapse is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_q <= crst_pkg::MAIN_CLK_CTRL_RESET[crst_pkg::ELAPSED_BIT]; // see R17
    end else if (tb_wrap) begin
      elapsed_q <= 1'b1; // see R16
    end else if (rd_main) begin
      elapsed_q <= 1'b0; // see R16
    end
  end

  always_comb begin
    case (sel_act_q)
      2'h0: limit = crst_pkg::TB_CNT_W'(TB_PERIOD_0); // see R13
      2'h1: limit = crst_pkg::TB_CNT_W'(TB_PERIOD_1);
      2'h2: limit = crst_pkg::TB_CNT_W'(TB_PERIOD_2);
      default: limit = crst_pkg::TB_CNT_W'(TB_PERIOD_3);
    endcase
  end

  assign tb_wrap = (state_q != crst_pkg::CRST_HALT) && (cnt_q == limit - 1'b1);

  // oscillator is off in full halt, so the counter freezes there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= '0;
      sel_act_q <= crst_pkg::MAIN_CLK_CTRL_RESET[crst_pkg::TB_SEL_HI_BIT:crst_pkg::TB_SEL_LO_BIT];
    end else if (tb_wrap) begin
      cnt_q     <= '0; // see R22
      sel_act_q <= tb_sel_q; // see R14
    end else if (state_q != crst_pkg::CRST_HALT) begin
      cnt_q     <= cnt_q + 1'b1;
    end
  end

  // reset status register: guard enable is plain read/write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_ie_q <= crst_pkg::RST_SRC_RESET[crst_pkg::GUARD_IE_BIT]; // see R10
    end else if (wr_rst) begin
      guard_ie_q <= wbyte_q[crst_pkg::GUARD_IE_BIT]; // see R4
    end
  end

  // cause flags are loaded while reset is held, so they outlive the reset itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (brownout_reset_cause && brownout_detector_enable) begin
        brownout_q <= 1'b1; // see R2 R8 R10
      end else if (!brownout_detector_enable) begin
        brownout_q <= 1'b0; // see R3
      end
    end else if (wr_rst && !wbyte_q[crst_pkg::BOR_RF_BIT]) begin
      brownout_q <= 1'b0; // see R2 R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (brownout_reset_cause) begin
        watchdog_q <= 1'b0; // see R7 R8
      end else if (watchdog_reset_cause) begin
        watchdog_q <= 1'b1; // see R7 R8
      end
    end else if (wr_rst && !wbyte_q[crst_pkg::WDG_RF_BIT]) begin
      watchdog_q <= 1'b0; // see R7
    end
  end

  // a read while the oscillator is still failed leaves the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safe_q <= crst_pkg::RST_SRC_RESET[crst_pkg::SAFE_CLK_BIT]; // see R10
    end else if (!clock_guard_enable) begin
      safe_q <= 1'b0; // see R6
    end else if (osc_failed) begin
      safe_q <= 1'b1; // see R5
    end else if (rd_rst) begin
      safe_q <= 1'b0; // see R5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      use_safe_q <= 1'b0;
    end else begin
      use_safe_q <= clock_guard_enable && osc_failed; // see R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_req_q    <= 1'b0;
      guard_req_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      tb_req_q    <= elapsed_q && tb_ie_q; // see R21
      guard_req_q <= safe_q && guard_ie_q && clock_guard_enable; // see R4 R21
      irq_q       <= (elapsed_q && tb_ie_q) || (safe_q && guard_ie_q && clock_guard_enable); // see R19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= crst_pkg::CRST_RUN;
      halt_q  <= 1'b0;
      thalt_q <= 1'b0;
    end else begin
      case (state_q)
        crst_pkg::CRST_RUN: begin
          if (halt_request) begin
            state_q <= tb_ie_q ? crst_pkg::CRST_TIMED_HALT : crst_pkg::CRST_HALT; // see R15
            halt_q  <= !tb_ie_q;
            thalt_q <= tb_ie_q;
          end
        end
        default: begin
          if (halt_wake || irq_q) begin
            state_q <= crst_pkg::CRST_RUN; // see R19
            halt_q  <= 1'b0;
            thalt_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // pin held low when disabled so a re-enable starts from a known phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_q <= 1'b0;
      clk_oe_q  <= 1'b0;
    end else begin
      clk_oe_q <= clock_out_enable; // see R11
      if (!clock_out_enable) begin
        clk_out_q <= 1'b0;
      end else if (state_q == crst_pkg::CRST_RUN) begin
        clk_out_q <= !clk_out_q; // see R11 R12
      end
    end
  end

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reserved_read_zero: assert property (rvalid_q |-> rdata_q[31:8] == 24'h000000 // see R1
    && (rd_sel_q != crst_pkg::CRST_SEL_MAIN || rdata_q[7:4] == 4'h0)
    && (rd_sel_q != crst_pkg::CRST_SEL_RST || (rdata_q[7:5] == 3'h0 && !rdata_q[3])))
    else $error("reserved register bit read as one");
  chk_brownout_sticky: assert property (brownout_q && !wr_rst |=> brownout_q) // see R9
    else $error("brownout flag lost without a software clear");
  chk_brownout_write_clear: assert property (wr_rst && !wbyte_q[crst_pkg::BOR_RF_BIT] |=> !brownout_q) // see R2
    else $error("brownout flag not cleared by write of zero");
  chk_watchdog_clear: assert property (wr_rst && !wbyte_q[crst_pkg::WDG_RF_BIT] |=> !watchdog_q) // see R7
    else $error("watchdog flag not cleared by write of zero");
  chk_safe_forced_zero: assert property (!clock_guard_enable |=> !safe_q ##1 !safe_q || clock_guard_enable) // see R6
    else $error("safe clock flag set while guard disabled");
  chk_safe_held: assert property (clock_guard_enable && osc_failed |=> safe_q && use_safe_q) // see R5
    else $error("safe clock flag or source not following failure");
  chk_clkout_frozen: assert property (state_q == crst_pkg::CRST_TIMED_HALT && clock_out_enable |=> $stable(clk_out_q)) // see R12
    else $error("clock out toggled in timed halt");
  chk_clkout_toggle: assert property (state_q == crst_pkg::CRST_RUN && clock_out_enable [*2] |=> clk_out_q != $past(clk_out_q)) // see R11
    else $error("clock out not toggling");
  chk_select_midperiod: assert property (!tb_wrap |=> $stable(sel_act_q)) // see R14
    else $error("time base select changed mid-period");
  chk_wrap_sets_flag: assert property (tb_wrap |=> elapsed_q && cnt_q == '0) // see R22
    else $error("period end did not set flag and restart counter");
  chk_read_clears_flag: assert property (rd_main && !tb_wrap |=> !elapsed_q) // see R16
    else $error("elapsed flag not cleared by read");
  chk_timed_halt_entry: assert property (state_q == crst_pkg::CRST_RUN && halt_request && tb_ie_q // see R15
    |=> state_q == crst_pkg::CRST_TIMED_HALT)
    else $error("halt with time base enable did not enter timed halt");
  // a halt request in the same cycle may still enter halt; the request then wakes it
  chk_irq_wakes: assert property (elapsed_q && tb_ie_q |=> irq_q ##1 (state_q == crst_pkg::CRST_RUN || $past(halt_request))) // see R19 R21
    else $error("time base request failed to raise and wake");

  cov_period_irq: cover property (tb_wrap && tb_ie_q ##1 irq_q);
  cov_timed_halt_wake: cover property (state_q == crst_pkg::CRST_TIMED_HALT ##1 state_q == crst_pkg::CRST_RUN);
  cov_write_resp: cover property (wr_fire ##1 bvalid_q && s_axi_bready);
  cov_safe_recover: cover property (safe_q && !osc_failed && rd_rst ##1 !safe_q);

endmodule

// ### verilog/crst_pkg.sv
/*
  constants, register map and types of the clock/reset status and time base block.
  assumes a single 100 mhz oscillator clock and an axi4-lite register bus.
*/
package crst_pkg;

  // bus geometry and answers
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] MAIN_CLK_CTRL_IDX  = 8'h29;
  localparam logic [7:0] RST_SRC_IDX        = 8'h2b;
  localparam logic [7:0] MAIN_CLK_CTRL_ADDR = 8'(MAIN_CLK_CTRL_IDX * 4);
  localparam logic [7:0] RST_SRC_ADDR       = 8'(RST_SRC_IDX * 4);

  // main_clock_control_status fields
  localparam int unsigned ELAPSED_BIT    = 0;
  localparam int unsigned TB_IE_BIT      = 1;
  localparam int unsigned TB_SEL_LO_BIT  = 2;
  localparam int unsigned TB_SEL_HI_BIT  = 3;
  localparam logic [7:0]  MAIN_CLK_CTRL_RESET = 8'h01;

  // reset_source_clock_guard_status fields
  localparam int unsigned WDG_RF_BIT     = 0;
  localparam int unsigned SAFE_CLK_BIT   = 1;
  localparam int unsigned GUARD_IE_BIT   = 2;
  localparam int unsigned BOR_RF_BIT     = 4;
  localparam logic [7:0]  RST_SRC_RESET  = 8'h00;

  // time base periods in oscillator cycles
  localparam int unsigned TB_CNT_W    = 19;
  localparam int unsigned TB_PERIOD_0 = 32000;
  localparam int unsigned TB_PERIOD_1 = 64000;
  localparam int unsigned TB_PERIOD_2 = 160000;
  localparam int unsigned TB_PERIOD_3 = 400000;

  typedef enum logic [1:0] {
    CRST_SEL_NONE,
    CRST_SEL_MAIN,
    CRST_SEL_RST
  } crst_sel_t;

  typedef enum logic [1:0] {
    CRST_RUN,
    CRST_HALT,
    CRST_TIMED_HALT
  } crst_state_t;

endpackage

// ### verif/crst_top_tb_top.sv
/*
  self-checking bench for crst_top: register bus, reset cause flags, clock guard,
  time base periods, halt modes and half-rate clock out.
  assumes the synchronous active-low reset and shortened time base periods.
*/
`timescale 1ns/1ps
module crst_top_tb_top;
  localparam int unsigned PER [4] = '{40, 60, 80, 100};
  localparam int unsigned LIMIT   = 20000;
  localparam logic [7:0]  A_MAIN  = crst_pkg::MAIN_CLK_CTRL_ADDR;
  localparam logic [7:0]  A_RST   = crst_pkg::RST_SRC_ADDR;
  localparam logic [1:0]  OK      = crst_pkg::RESP_OKAY;
  localparam logic [1:0]  BAD     = crst_pkg::RESP_SLVERR;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        bo_cause;
  logic        wd_cause;
  logic        bo_det_en;
  logic        guard_en;
  logic        osc_failed;
  logic        clk_out_en;
  logic        halt_req;
  logic        halt_wake;
  logic        use_safe;
  logic        clk_out;
  logic        clk_out_oe;
  logic        halt_act;
  logic        thalt_act;
  logic        tb_irq;
  logic        cg_irq;
  logic        sh_irq;
  logic        irq_d;
  int          cyc;
  int          t_prev;
  int          t_last;
  int          n_rise;
  int          err_count;
  int          checks;

  crst_top #(.TB_PERIOD_0(PER[0]), .TB_PERIOD_1(PER[1]), .TB_PERIOD_2(PER[2]), .TB_PERIOD_3(PER[3])) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brownout_reset_cause(bo_cause), .watchdog_reset_cause(wd_cause), .brownout_detector_enable(bo_det_en),
    .clock_guard_enable(guard_en), .osc_failed(osc_failed), .clock_out_enable(clk_out_en),
    .halt_request(halt_req), .halt_wake(halt_wake), .clock_use_safe(use_safe), .clock_out(clk_out),
    .clock_out_oe(clk_out_oe), .halt_active(halt_act), .timed_halt_active(thalt_act),
    .timebase_irq_req(tb_irq), .clock_guard_irq_req(cg_irq), .shared_irq(sh_irq));

  always #5 aclk = ~aclk;

  // rise times of the time base request, used to measure periods
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (tb_irq === 1'b1 && irq_d !== 1'b1) begin
      t_prev = t_last;
      t_last = cyc;
      n_rise = n_rise + 1;
    end
    irq_d = tb_irq;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] exp);
    @(posedge aclk);
    awaddr  <= addr;
    wdata   <= {24'h0, data};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk("bresp", {30'h0, exp}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [1:0] er;
    er = (addr == A_MAIN || addr == A_RST) ? OK : BAD;
    @(posedge aclk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk("rdata", {24'h0, exp}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic do_reset(input logic bo, input logic wd);
    @(posedge aclk);
    aresetn  <= 1'b0;
    bo_cause <= bo;
    wd_cause <= wd;
    repeat (2) @(posedge aclk);
    aresetn  <= 1'b1;
    bo_cause <= 1'b0;
    wd_cause <= 1'b0;
  endtask

  task automatic wait_rise();
    int n0;
    n0 = n_rise;
    while (n_rise == n0) @(negedge aclk);
  endtask

  task automatic pulse_halt(input logic wake);
    @(posedge aclk);
    if (wake) halt_wake <= 1'b1;
    else halt_req <= 1'b1;
    @(posedge aclk);
    halt_wake <= 1'b0;
    halt_req  <= 1'b0;
    @(negedge aclk);
  endtask

  task automatic t_timebase();
    logic [7:0] sel;
    wr(A_MAIN, 8'h02, OK);
    wait_rise();
    chkb("tb irq", 1'b1, tb_irq);
    rd(A_MAIN, 8'h03);
    for (int s = 1; s <= 4; s++) begin
      sel = 8'(s % 4);
      // whole-byte writes only, never read-modify-write
      wr(A_MAIN, 8'hf2 | (sel << 2), OK);
      wait_rise();
      chk("old period", 32'(PER[s - 1]), 32'(t_last - t_prev));
      rd(A_MAIN, 8'h03 | (sel << 2));
      wait_rise();
      chk("period", 32'(PER[s % 4]), 32'(t_last - t_prev));
      rd(A_MAIN, 8'h03 | (sel << 2));
    end
  endtask

  task automatic t_halt();
    logic c1;
    @(posedge aclk);
    clk_out_en <= 1'b1;
    repeat (2) @(negedge aclk);
    c1 = clk_out;
    @(negedge aclk);
    chkb("clock out toggles", ~c1, clk_out);
    chkb("clock out oe", 1'b1, clk_out_oe);
    pulse_halt(1'b0);
    chkb("timed halt", 1'b1, thalt_act);
    c1 = clk_out;
    repeat (3) @(negedge aclk);
    chkb("clock out frozen", c1, clk_out);
    wait_rise();
    @(negedge aclk);
    chkb("timed halt woken", 1'b0, thalt_act);
    rd(A_MAIN, 8'h03);
    wr(A_MAIN, 8'h00, OK);
    pulse_halt(1'b0);
    chkb("full halt", 1'b1, halt_act);
    pulse_halt(1'b1);
    chkb("full halt woken", 1'b0, halt_act);
  endtask

  task automatic t_flags();
    do_reset(1'b0, 1'b1);
    rd(A_RST, 8'h11);
    wr(A_RST, 8'he8, OK);
    rd(A_RST, 8'h00);
    do_reset(1'b0, 1'b0);
    rd(A_RST, 8'h00);
    do_reset(1'b0, 1'b1);
    rd(A_RST, 8'h01);
    do_reset(1'b1, 1'b0);
    rd(A_RST, 8'h10);
    do_reset(1'b0, 1'b0);
    rd(A_RST, 8'h10);
    wr(A_RST, 8'h15, OK);
    rd(A_RST, 8'h14);
    wr(8'h00, 8'h55, BAD);
    rd(8'h00, 8'h00);
    rd(A_RST, 8'h14);
  endtask

  task automatic t_guard();
    @(posedge aclk);
    osc_failed <= 1'b1;
    repeat (3) @(negedge aclk);
    chkb("use safe", 1'b1, use_safe);
    chkb("guard irq", 1'b1, cg_irq);
    chkb("shared irq", 1'b1, sh_irq);
    rd(A_RST, 8'h16);
    rd(A_RST, 8'h16);
    @(posedge aclk);
    osc_failed <= 1'b0;
    repeat (2) @(negedge aclk);
    chkb("back to main", 1'b0, use_safe);
    rd(A_RST, 8'h16);
    rd(A_RST, 8'h14);
    @(posedge aclk);
    guard_en   <= 1'b0;
    osc_failed <= 1'b1;
    repeat (3) @(negedge aclk);
    chkb("guard off safe", 1'b0, use_safe);
    rd(A_RST, 8'h14);
    chkb("guard off irq", 1'b0, cg_irq);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {wd_cause, osc_failed, clk_out_en, halt_req, halt_wake, irq_d} = '0;
    {bo_cause, bo_det_en, guard_en} = 3'h7;
    {cyc, t_prev, t_last, n_rise, err_count, checks} = '0;
    repeat (20) @(posedge aclk);
    aresetn  <= 1'b1;
    bo_cause <= 1'b0;
    rd(A_MAIN, 8'h01);
    rd(A_MAIN, 8'h00);
    rd(A_RST, 8'h10);
    t_timebase();
    t_halt();
    t_flags();
    t_guard();
    print_verdict();
  end
endmodule
